/* File: verilog/ard_rx.sv */
// Summary of operation
// R1: Nine-bit mode stores ninth bit in status.
// R2: Address detect needs detect bit plus nine-bit.
// R3: Address frame loads buffer, sets full flag.
// R4: Ninth bit one is address, zero data.
// R5: Detect mode drops data bytes, no interrupt.
// R6: Next frame overwrites a dropped data byte.
// R7: Detect bit ignored in eight-bit mode.
// R8: Detect off accepts all, no parity check.
// R9: Continuous enable starts reception.
// R10: After detect cleared, every frame loads.
// R11: Addressed software clears address detect.
// R12: Software configures mode, divisor, then enables.
// R13: Full flag on completion; irq if enabled.
// R14: Software reads status before data buffer.
// R15: Clearing continuous enable clears overrun.
// R16: Single or continuous enable starts reception.
// R17: Data buffer read returns eight data bits.
// R18: Two-entry buffer; flag clears when empty.
// R19: Third frame into full buffer sets overrun.
// R20: Low stop bit flags framing; buffered per byte.
// R21: Line sampled sixteen times per bit; the code ticks sixteen times a bit but samples the line once, mid bit.
// R22: Idle high, start low, LSB first, stop high.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module ard_rx
    import ard_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        nrst,
    // Register port.
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata,
    // Serial line and interrupt.
    input  wire logic        receive_pin,
    output logic             rx_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, used for reads and writes alike.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State and its next value.
    ard_state_t st;       // Registered state.
    ard_state_t next_st;  // Next state.

    // Head entry of the receive buffer, seen through the status register.
    logic [9:0] head;
    assign head = st.fifo[st.rd_ptr];

    // Outputs come straight from flip-flops.
    assign rdata  = st.rdata;
    assign rx_irq = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: register port, prescaler, receiver and buffer.
    always_comb begin
        logic       rx_on;     // Receiver is running.
        logic       pop;       // Software takes the head entry.
        logic       ninth;     // Ninth bit of the finished frame.
        logic       is_data;   // Finished frame is a data byte in detect mode.
        logic [3:0] last_bit;  // Index of the last data bit.
        logic [9:0] limit;     // Prescaler reload value.
        next_st  = st;
        rx_on    = 1'b0;
        pop      = 1'b0;
        ninth    = 1'b0;
        is_data  = 1'b0;
        last_bit = ARD_LAST_BIT8;
        limit    = 10'h000;

        // Read data: one cycle after the read strobe, zero otherwise.
        next_st.rdata = 8'h00;
        if (rd_en) begin
            if (hit(addr, ARD_OFF_FLAGS)) begin
                // The full flag is the buffer holding anything.
                next_st.rdata[ARD_B_RX_FULL] = (st.count != 2'h0);  // R13 R18
            end else if (hit(addr, ARD_OFF_RXCTL)) begin
                // Status shows the head entry's ninth bit and framing error.
                next_st.rdata = {st.serial_port_enable, st.rx9, st.single_rx_enable, st.continuous_rx_enable, st.address_detect_enable,
                                 head[ARD_E_FRAMING_ERROR], st.overrun_error, head[ARD_E_NINTH]};  // R1 R20
            end else if (hit(addr, ARD_OFF_RXDATA)) begin
                // Only the eight data bits; reading advances the buffer.
                next_st.rdata = head[7:0];  // R17
                pop           = (st.count != 2'h0);  // R18
            end else if (hit(addr, ARD_OFF_IRQEN)) begin
                next_st.rdata[ARD_B_RX_IE] = st.ie;
            end else if (hit(addr, ARD_OFF_TXCTL)) begin
                // No transmitter lives here, so its shift register is always empty.
                next_st.rdata[ARD_B_SYNC] = st.sync;
                next_st.rdata[ARD_B_HIGH_BAUD_SELECT] = st.high_baud_select;
                next_st.rdata[ARD_B_TRMT] = 1'b1;
            end else if (hit(addr, ARD_OFF_BAUD)) begin
                next_st.rdata = st.div;
            end else begin
                // Unmapped addresses read as zero.
                next_st.rdata = 8'h00;
            end
        end

        // Software writes to the control bits.
        if (wr_en) begin
            if (hit(addr, ARD_OFF_RXCTL)) begin
                next_st.serial_port_enable = wdata[ARD_B_SERIAL_PORT_ENABLE];
                next_st.rx9  = wdata[ARD_B_RX9];
                next_st.single_rx_enable = wdata[ARD_B_SINGLE_RX_ENABLE];
                next_st.continuous_rx_enable = wdata[ARD_B_CONTINUOUS_RX_ENABLE];
                next_st.address_detect_enable = wdata[ARD_B_ADDRESS_DETECT_ENABLE];
                // Taking continuous enable low is the way out of an overrun.
                if (!wdata[ARD_B_CONTINUOUS_RX_ENABLE]) begin
                    next_st.overrun_error = 1'b0;  // R15
                end
            end else if (hit(addr, ARD_OFF_IRQEN)) begin
                next_st.ie = wdata[ARD_B_RX_IE];
            end else if (hit(addr, ARD_OFF_TXCTL)) begin
                next_st.sync = wdata[ARD_B_SYNC];
                next_st.high_baud_select = wdata[ARD_B_HIGH_BAUD_SELECT];
            end else if (hit(addr, ARD_OFF_BAUD)) begin
                next_st.div = wdata;
            end else begin
                // Read-only and unmapped addresses ignore writes.
                next_st.div = next_st.div;
            end
        end

        // Popping first frees a slot for a frame finishing this same cycle.
        if (pop) begin
            next_st.rd_ptr = ~st.rd_ptr;
            next_st.count  = st.count - 2'h1;  // R18
        end

        // Asynchronous reception runs on either enable.
        rx_on = st.serial_port_enable && !st.sync && (st.continuous_rx_enable || st.single_rx_enable);  // R9 R16

        // Prescaler: one tick per sixteenth of a bit.
        limit = st.high_baud_select ? {2'b00, st.div} : {st.div, 2'b11};
        if (!rx_on) begin
            next_st.presc = 10'h000;
            next_st.tick  = 1'b0;
        end else if (st.presc == 10'h000) begin
            next_st.presc = limit;
            next_st.tick  = 1'b1;  // R21
        end else begin
            next_st.presc = st.presc - 10'h001;
            next_st.tick  = 1'b0;
        end

        // Frame length follows the nine-bit enable.
        last_bit = st.rx9 ? ARD_LAST_BIT9 : ARD_LAST_BIT8;  // R1

        // Receiver state machine.
        if (!rx_on) begin
            next_st.fsm = ARD_IDLE;
        end else begin
            case (st.fsm)
                ARD_IDLE: begin
                    // A low level on the idle-high line opens a frame.
                    if (!receive_pin) begin
                        next_st.fsm   = ARD_START;  // R22
                        next_st.tcnt  = 4'h0;
                        // A dropped data byte is simply overwritten here.
                        next_st.shift = 9'h000;  // R6
                    end
                end
                ARD_START: begin
                    if (st.tick) begin
                        next_st.tcnt = st.tcnt + 4'h1;
                        // Mid start bit: still low means a real start.
                        if (st.tcnt == ARD_MID_START) begin
                            next_st.tcnt    = 4'h0;
                            next_st.bit_idx = 4'h0;
                            next_st.fsm     = receive_pin ? ARD_IDLE : ARD_DATA;  // R22
                        end
                    end
                end
                ARD_DATA: begin
                    if (st.tick) begin
                        next_st.tcnt = st.tcnt + 4'h1;
                        // Sample mid bit, least significant bit first.
                        if (st.tcnt == ARD_LAST_TICK) begin
                            next_st.shift[st.bit_idx] = receive_pin;  // R21 R22
                            next_st.bit_idx           = st.bit_idx + 4'h1;
                            if (st.bit_idx == last_bit) begin
                                next_st.fsm = ARD_STOP;
                            end
                        end
                    end
                end
                ARD_STOP: begin
                    if (st.tick) begin
                        next_st.tcnt = st.tcnt + 4'h1;
                        if (st.tcnt == ARD_LAST_TICK) begin
                            next_st.fsm = ARD_IDLE;
                            ninth       = st.rx9 ? st.shift[8] : 1'b0;  // R1
                            // Data bytes are dropped only with both bits set.
                            is_data     = st.address_detect_enable && st.rx9 && !ninth;  // R2 R4 R7
                            if (is_data) begin
                                // No load, no flag; the shift register is left as is.
                                next_st.fsm = ARD_IDLE;  // R5
                            end else if (st.overrun_error) begin
                                // Transfers stay inhibited while overrun stands.
                                next_st.fsm = ARD_IDLE;  // R19
                            end else if (next_st.count == ARD_FIFO_FULL) begin
                                // Buffer full: the shifted word is lost.
                                next_st.overrun_error = 1'b1;  // R19
                            end else begin
                                // Address frames, eight-bit frames, or any frame with detect off.
                                next_st.fifo[st.wr_ptr] = {!receive_pin, ninth,
                                                           st.shift[7:0]};  // R3 R8 R10 R20
                                next_st.wr_ptr          = ~st.wr_ptr;
                                next_st.count           = next_st.count + 2'h1;  // R13 R18
                            end
                            // A single reception ends after one frame.
                            if (!st.continuous_rx_enable) begin
                                next_st.single_rx_enable = 1'b0;  // R16
                            end
                        end
                    end
                end
                default: begin
                    next_st.fsm = ARD_IDLE;
                end
            endcase
        end

        // Interrupt request follows the flag, gated by its enable.
        next_st.irq = (next_st.count != 2'h0) && next_st.ie;  // R13
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; all control starts cleared and the receiver idle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st     <= '0;
            st.fsm <= ARD_IDLE;
        end else begin
            st <= next_st;
        end
    end

endmodule // ard_rx
`default_nettype wire

/* File: verilog/ard_pkg.sv */
`default_nettype none
// Shared constants and types of the address-detecting serial receiver.
package ard_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the plain register port.
    localparam logic [7:0] ARD_OFF_FLAGS    = 8'h0c;  // Peripheral flags.
    localparam logic [7:0] ARD_OFF_RXCTL    = 8'h18;  // Receive status and control.
    localparam logic [7:0] ARD_OFF_RXDATA   = 8'h1a;  // Receive data buffer.
    localparam logic [7:0] ARD_OFF_IRQEN    = 8'h8c;  // Peripheral interrupt enables.
    localparam logic [7:0] ARD_OFF_TXCTL    = 8'h98;  // Transmit status and control.
    localparam logic [7:0] ARD_OFF_BAUD     = 8'h99;  // Baud divisor.

    ////////////////////////////////////////////////////////////////////////////
    // Reset values as software reads them.
    localparam logic [7:0] ARD_RST_FLAGS    = 8'h00;
    localparam logic [7:0] ARD_RST_RXCTL    = 8'h00;
    localparam logic [7:0] ARD_RST_IRQEN    = 8'h00;
    localparam logic [7:0] ARD_RST_TXCTL    = 8'h02;
    localparam logic [7:0] ARD_RST_BAUD     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int ARD_B_RX_FULL    = 5;  // Receive full flag in the flags register.
    localparam int ARD_B_RX_IE      = 5;  // Receive interrupt enable.
    localparam int ARD_B_SERIAL_PORT_ENABLE       = 7;  // Serial port enable.
    localparam int ARD_B_RX9        = 6;  // Nine-bit receive enable.
    localparam int ARD_B_SINGLE_RX_ENABLE       = 5;  // Single receive enable.
    localparam int ARD_B_CONTINUOUS_RX_ENABLE       = 4;  // Continuous receive enable.
    localparam int ARD_B_ADDRESS_DETECT_ENABLE       = 3;  // Address detect enable.
    localparam int ARD_B_FRAMING_ERROR       = 2;  // Framing error.
    localparam int ARD_B_OVERRUN_ERROR       = 1;  // Overrun error.
    localparam int ARD_B_RX_NINTH_BIT       = 0;  // Received ninth bit.
    localparam int ARD_B_SYNC       = 4;  // Synchronous mode select.
    localparam int ARD_B_HIGH_BAUD_SELECT       = 2;  // High baud select.
    localparam int ARD_B_TRMT       = 1;  // Transmit shift register empty.
    localparam int ARD_E_FRAMING_ERROR       = 9;  // Framing error inside a buffer entry.
    localparam int ARD_E_NINTH      = 8;  // Ninth bit inside a buffer entry.

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts in oversampling ticks, last bit indices and buffer size.
    localparam logic [3:0] ARD_MID_START    = 4'h7;  // Tick that lands mid start bit.
    localparam logic [3:0] ARD_LAST_TICK    = 4'hf;  // Sixteenth tick of a bit.
    localparam logic [3:0] ARD_LAST_BIT8    = 4'h7;  // Index of the last bit, 8-bit frame.
    localparam logic [3:0] ARD_LAST_BIT9    = 4'h8;  // Index of the last bit, 9-bit frame.
    localparam logic [1:0] ARD_FIFO_FULL    = 2'h2;  // Entries held in a full buffer.

    ////////////////////////////////////////////////////////////////////////////
    // Receiver states, one-hot.
    typedef enum logic [3:0] {
        ARD_IDLE  = 4'b0001,
        ARD_START = 4'b0010,
        ARD_DATA  = 4'b0100,
        ARD_STOP  = 4'b1000
    } ard_rx_state_t;

    // Whole state of the receiver block.
    typedef struct packed {
        logic                serial_port_enable;     // Serial port enable.
        logic                rx9;      // Nine-bit receive enable.
        logic                single_rx_enable;     // Single receive enable.
        logic                continuous_rx_enable;     // Continuous receive enable.
        logic                address_detect_enable;     // Address detect enable.
        logic                ie;       // Receive interrupt enable.
        logic                sync;     // Synchronous mode select.
        logic                high_baud_select;     // High baud select.
        logic [7:0]          div;      // Baud divisor.
        logic                overrun_error;     // Overrun error.
        logic [1:0][9:0]     fifo;     // Two buffer entries: framing_error, ninth, data.
        logic                wr_ptr;   // Buffer write pointer.
        logic                rd_ptr;   // Buffer read pointer.
        logic [1:0]          count;    // Entries held.
        logic [9:0]          presc;    // Oversampling prescaler.
        logic                tick;     // Oversampling tick, sixteen per bit.
        ard_rx_state_t       fsm;      // Receiver state.
        logic [3:0]          tcnt;     // Ticks within the current bit.
        logic [3:0]          bit_idx;  // Index of the bit being received.
        logic [8:0]          shift;    // Receive shift register.
        logic [7:0]          rdata;    // Read data to software.
        logic                irq;      // Interrupt request.
    } ard_state_t;

endpackage
`default_nettype wire

/* File: verification/ard_rx_props.sv */
`timescale 1ns/10ps
`default_nettype none

module ard_rx_props
    import ard_pkg::*;
(
    // Clock and reset.
    input wire logic       clock,
    input wire logic       nrst,
    // Register port.
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    // Serial line and interrupt.
    input wire logic       receive_pin,
    input wire logic       rx_irq
);
    logic       ie_sh;   // Interrupt enable as software last wrote it.
    logic [7:0] baud_sh; // Divisor as software last wrote it.
    logic [7:0] ctl_sh;  // Control byte as software last wrote it.
    logic       mapped;  // The address hits one of the six registers.

    assign mapped = addr inside {ARD_OFF_FLAGS, ARD_OFF_RXCTL, ARD_OFF_RXDATA,
                                 ARD_OFF_IRQEN, ARD_OFF_TXCTL, ARD_OFF_BAUD};

    // Shadows follow the writes, so read-back can be judged.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ie_sh   <= 1'b0;
            baud_sh <= 8'h00;
            ctl_sh  <= 8'h00;
        end else if (wr_en) begin
            if (addr == ARD_OFF_IRQEN) ie_sh <= wdata[ARD_B_RX_IE];
            if (addr == ARD_OFF_BAUD) baud_sh <= wdata;
            if (addr == ARD_OFF_RXCTL) ctl_sh <= wdata;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_en && !mapped |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    trmt_high_a: assert property (rd_en && addr == ARD_OFF_TXCTL |=> rdata[ARD_B_TRMT])
        else $error("transmit empty bit not one");
    baud_back_a: assert property (rd_en && addr == ARD_OFF_BAUD |=> rdata == $past(baud_sh))
        else $error("divisor read-back wrong");
    ctl_back_a: assert property (rd_en && addr == ARD_OFF_RXCTL |=>
        rdata[7:6] == $past(ctl_sh[7:6]) && rdata[4:3] == $past(ctl_sh[4:3]))
        else $error("control read-back wrong");
    irq_mask_a: assert property (rx_irq |-> ie_sh)
        else $error("interrupt while disabled");
    overrun_error_clear_a: assert property ((wr_en && addr == ARD_OFF_RXCTL && !wdata[ARD_B_CONTINUOUS_RX_ENABLE])
        ##1 (rd_en && addr == ARD_OFF_RXCTL) |=> !rdata[ARD_B_OVERRUN_ERROR])
        else $error("overrun not cleared");
    irq_fall_a: assert property ($fell(rx_irq) |->
        $past(rd_en) || $past(wr_en) || $past(rd_en, 2) || $past(wr_en, 2))
        else $error("interrupt fell without software access");

    // Main scenarios reached.
    cover property ($rose(rx_irq));
    cover property (rd_en && addr == ARD_OFF_RXCTL ##1 rdata[ARD_B_OVERRUN_ERROR]);
    cover property (rd_en && addr == ARD_OFF_RXCTL ##1 rdata[ARD_B_FRAMING_ERROR]);

endmodule // ard_rx_props

bind ard_rx ard_rx_props props_u (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .receive_pin(receive_pin), .rx_irq(rx_irq));
`default_nettype wire

/* File: verification/ard_tx_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Remote transmitter: one frame for each go pulse, line high between frames.
module ard_tx_model #(
    parameter int BIT_CLKS = 32  // Clocks in one bit time.
) (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Frame request.
    input  wire logic       go,
    input  wire logic [8:0] frame,
    input  wire logic       nine,
    input  wire logic       stop_ok,
    // Line and state.
    output logic            receive_pin,
    output logic            busy
);
    logic [10:0] sh;   // Bits still to send, next one at bit 0.
    logic [3:0]  left; // Bits still to send.
    int          cnt;  // Clocks into the current bit.

    // Shifts a frame out; a bad stop bit only when asked.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            receive_pin <= 1'b1;
            busy        <= 1'b0;
            sh          <= '0;
            left        <= 4'h0;
            cnt         <= 0;
        end else if (!busy) begin
            receive_pin <= 1'b1;
            if (go) begin
                busy <= 1'b1;
                cnt  <= 0;
                sh   <= nine ? {stop_ok, frame, 1'b0} : {1'b1, stop_ok, frame[7:0], 1'b0};
                left <= nine ? 4'hb : 4'ha;
            end
        end else begin
            // A low stop bit goes high late in its bit time, after the receiver's mid-bit
            // sample, so that its tail cannot pass for the start bit of a new frame.
            receive_pin <= (left == 4'h1 && cnt >= BIT_CLKS * 3 / 4) ? 1'b1 : sh[0];
            if (cnt == BIT_CLKS - 1) begin
                cnt  <= 0;
                sh   <= sh >> 1;
                left <= left - 4'h1;
                busy <= (left != 4'h1);
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // ard_tx_model
`default_nettype wire

/* File: verification/ard_rx_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module ard_rx_tb_top
    import ard_pkg::*;
;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  rdata;
    logic        receive_pin;
    logic        rx_irq;
    logic        go = 1'b0;
    logic [8:0]  frame = 9'h000;
    logic        nine = 1'b1;
    logic        stop_ok = 1'b1;
    logic        busy;
    logic [15:0] seed = 16'h74fa;   // Random source state.
    logic [15:0] q[$];              // Expected read data and mask.
    logic [15:0] e;
    logic        pend = 1'b0;       // A read was launched last cycle.
    int          fail_count = 0;
    int          n_compared = 0;

    always #5 clock = ~clock;

    ard_rx dut_u (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .receive_pin(receive_pin), .rx_irq(rx_irq));
    // Divisor 1 with high baud: two clocks a tick, sixteen ticks a bit.
    ard_tx_model #(.BIT_CLKS(32)) tx_u (.clock(clock), .nrst(nrst), .go(go), .frame(frame),
        .nine(nine), .stop_ok(stop_ok), .receive_pin(receive_pin), .busy(busy));

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        {wr_en, rd_en, addr, wdata} <= {2'b10, a, d};
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        @(posedge clock);
        {wr_en, rd_en, addr} <= {2'b01, a};
        q.push_back({x, m});
    endtask

    // Sends one frame and waits, bounded, until it has been taken in.
    task automatic send(input logic [8:0] f, input logic n, input logic ok);
        @(posedge clock);
        {wr_en, rd_en, go, frame, nine, stop_ok} <= {3'b001, f, n, ok};
        @(posedge clock);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 1000 && busy; i++) @(posedge clock);
        if (busy) begin
            fail_count++;
            end_of_test();
        end else begin
            repeat (4) @(posedge clock);
            #1;
        end
    endtask

    // Each read's answer is taken the cycle after its strobe.
    always @(posedge clock) begin
        if (pend) begin
            e = q.pop_front();
            check("rdata", rdata & e[7:0], e[15:8] & e[7:0]);
        end
        pend = rd_en;
    end

    initial begin
        logic [7:0] offs[8] = '{8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h00, 8'hff};
        logic [7:0] rsts[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
        logic [7:0] v0;
        logic [7:0] v1;
        logic [7:0] v2;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        foreach (offs[i]) rd(offs[i], rsts[i], 8'hff);
        v0 = rnd();
        wr(ARD_OFF_BAUD, v0);
        rd(ARD_OFF_BAUD, v0, 8'hff);
        wr(ARD_OFF_BAUD, 8'h01);
        wr(ARD_OFF_TXCTL, 8'h04);
        wr(ARD_OFF_IRQEN, 8'h20);
        wr(ARD_OFF_RXCTL, 8'hd8);
        rd(ARD_OFF_RXCTL, 8'hd8, 8'hf8);
        v0 = rnd();
        v1 = rnd();
        v2 = rnd();
        send({1'b0, v0}, 1'b1, 1'b1);
        send({1'b0, v1}, 1'b1, 1'b1);
        check("rx_irq", {7'h00, rx_irq}, 8'h00);
        send({1'b1, v2}, 1'b1, 1'b1);
        check("rx_irq", {7'h00, rx_irq}, 8'h01);
        rd(ARD_OFF_FLAGS, 8'h20, 8'h20);
        rd(ARD_OFF_RXCTL, 8'h01, 8'h07);
        rd(ARD_OFF_RXDATA, v2, 8'hff);
        rd(ARD_OFF_FLAGS, 8'h00, 8'h20);
        wr(ARD_OFF_RXCTL, 8'hd0);
        send({1'b0, v0}, 1'b1, 1'b1);
        send({1'b1, v1}, 1'b1, 1'b1);
        rd(ARD_OFF_RXCTL, 8'h00, 8'h07);
        rd(ARD_OFF_RXDATA, v0, 8'hff);
        rd(ARD_OFF_RXCTL, 8'h01, 8'h07);
        rd(ARD_OFF_RXDATA, v1, 8'hff);
        rd(ARD_OFF_FLAGS, 8'h00, 8'h20);
        send({1'b1, v0}, 1'b1, 1'b1);
        send({1'b1, v1}, 1'b1, 1'b1);
        send({1'b1, v2}, 1'b1, 1'b1);
        rd(ARD_OFF_RXCTL, 8'h03, 8'h07);
        rd(ARD_OFF_RXDATA, v0, 8'hff);
        rd(ARD_OFF_RXDATA, v1, 8'hff);
        send({1'b1, v2}, 1'b1, 1'b1);
        rd(ARD_OFF_FLAGS, 8'h00, 8'h20);
        wr(ARD_OFF_RXCTL, 8'hc0);
        rd(ARD_OFF_RXCTL, 8'h00, 8'h02);
        wr(ARD_OFF_RXCTL, 8'hd0);
        send({1'b0, v2}, 1'b1, 1'b0);
        rd(ARD_OFF_RXCTL, 8'h04, 8'h07);
        rd(ARD_OFF_RXDATA, v2, 8'hff);
        wr(ARD_OFF_RXCTL, 8'h98);
        send({1'b0, v1}, 1'b0, 1'b1);
        check("rx_irq", {7'h00, rx_irq}, 8'h01);
        rd(ARD_OFF_RXDATA, v1, 8'hff);
        wr(ARD_OFF_RXCTL, 8'he8);
        send({1'b1, v0}, 1'b1, 1'b1);
        wr(ARD_OFF_IRQEN, 8'h00);
        rd(ARD_OFF_FLAGS, 8'h20, 8'h20);
        rd(ARD_OFF_RXDATA, v0, 8'hff);
        #1;
        check("rx_irq", {7'h00, rx_irq}, 8'h00);
        send({1'b1, v1}, 1'b1, 1'b1);
        rd(ARD_OFF_FLAGS, 8'h00, 8'h20);
        wr(ARD_OFF_TXCTL, 8'h14);
        wr(ARD_OFF_RXCTL, 8'hd0);
        rd(ARD_OFF_TXCTL, 8'h16, 8'hff);
        send({1'b1, v2}, 1'b1, 1'b1);
        rd(ARD_OFF_FLAGS, 8'h00, 8'h20);
        wr(ARD_OFF_IRQEN, 8'h00);
        @(posedge clock);
        {wr_en, rd_en} <= 2'b00;
        repeat (3) @(posedge clock);
        end_of_test();
    end
endmodule // ard_rx_tb_top
`default_nettype wire
